// ---- hdl/phase_delay_line.sv ----
`timescale 1ns/100ps
// Programmable delay of a one-bit signal, tap output registered
module phase_delay_line
  import regclk_pkg::*;
#(
  parameter int DEPTH = DELAY_DEPTH,
  parameter int SEL_W = PHASE_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Signal path
  input wire logic data_i,
  input wire logic [SEL_W-1:0] shift_i,
  output logic data_o
);

  logic [DEPTH-1:0] taps_reg; // Bit 0 holds the input delayed by one cycle

  // Tap 0 follows the input combinationally so shift 0 adds no cycle
  logic [DEPTH-1:0] taps_all;
  assign taps_all = {taps_reg[DEPTH-2:0], data_i};

  // Shift chain, one stage per clock
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taps_reg <= '0;
    end else begin
      taps_reg <= taps_all;
    end
  end

  // Registered tap select; a fixed output stage keeps relative shifts exact
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 1'b0;
    end else begin
      data_o <= taps_all[shift_i];
    end
  end

endmodule

// ---- hdl/regclk_pkg.sv ----
// Behaviour
// - Per-regulator thermal action: shutdown, optionally deep fail-safe
// - Low-side gate drive: slow, medium, fast, ultra
// - High-side gate drive: same four-level encoding
// - Spread range bit selects 23 or 94 kHz
// - Modulation only while enable bit is one
// - Frequency output delayed by phase-field cycles
// - Clock choice bit picks first or second option
// - Writing one requests external input; reads zero
// - External input divided by one or six
// - Power-on reset restores every writable field
// - Live status: external input currently selected
// - Live status: PLL locked
package regclk_pkg;

  // Register access port geometry
  localparam int REG_DATA_W = 16;
  localparam int REG_SEL_W = 2;

  // Register selects
  localparam logic [REG_SEL_W-1:0] SEL_PROT = 2'h0;
  localparam logic [REG_SEL_W-1:0] SEL_OSC = 2'h1;
  localparam logic [REG_SEL_W-1:0] SEL_STATUS = 2'h2;

  // Regulator protection and slew register field positions
  localparam int POS_CORE_TSD = 12;
  localparam int POS_SECOND_TSD = 10;
  localparam int POS_LINEAR_TSD = 9;
  localparam int POS_LOW_SLEW = 3;
  localparam int POS_HIGH_SLEW = 0;

  // Oscillator register field positions
  localparam int POS_RANGE = 15;
  localparam int POS_SRC_SEL = 11;
  localparam int POS_PHASE = 8;
  localparam int POS_CLK_CHOICE = 7;
  localparam int POS_EXT_REQ = 6;
  localparam int POS_DIVIDER = 5;
  localparam int POS_SPREAD_EN = 4;
  localparam int POS_TUNE = 0;

  // Status register field positions
  localparam int POS_PLL_LOCK = 8;
  localparam int POS_EXT_ACTIVE = 7;

  // Read masks: reserved bits read as zero
  localparam logic [REG_DATA_W-1:0] PROT_RMASK = 16'h161B;
  localparam logic [REG_DATA_W-1:0] OSC_RMASK = 16'hFFBF;

  // Reset values
  localparam logic [1:0] LOW_SLEW_RESET = 2'h3;
  localparam logic [REG_DATA_W-1:0] OSC_RESET = 16'h0000;

  // Timing and counts
  localparam int SYNC_STAGES = 2;
  localparam int PHASE_W = 3;
  localparam int DELAY_DEPTH = 8;
  localparam int EXTERNAL_INPUT_DIVIDER_RATIO = 6;
  localparam int FIN_HALF_RATIO = EXTERNAL_INPUT_DIVIDER_RATIO / 2;
  localparam logic [1:0] FIN_HALF_LAST = 2'(FIN_HALF_RATIO - 1);

  // Gate drive strength encoding
  typedef enum logic [1:0] {
    SLEW_SLOW = 2'b00,
    SLEW_MEDIUM = 2'b01,
    SLEW_FAST = 2'b10,
    SLEW_ULTRA = 2'b11
  } slew_t;

  // Spread spectrum modulation range
  typedef enum logic {
    RANGE_23KHZ = 1'b0,
    RANGE_94KHZ = 1'b1
  } spread_range_t;

  // Start-up sequencing of the register bank
  typedef enum logic {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } bank_state_t;

  // Regulator protection and slew configuration
  typedef struct packed {
    logic core_buck_thermal_action;
    logic second_buck_thermal_action;
    logic linear_reg_thermal_action;
    slew_t prereg_lowside_slew;
    slew_t prereg_highside_slew;
  } prot_cfg_t;

  // Oscillator and clock configuration
  typedef struct packed {
    spread_range_t spread_range_select;
    logic [3:0] freq_out_source_select;
    logic [PHASE_W-1:0] freq_out_phase_shift;
    logic freq_out_clock_choice;
    logic external_input_divider;
    logic spread_spectrum_enable;
    logic [3:0] clock_tune;
  } osc_cfg_t;

endpackage

// ---- hdl/regulator_clock_config_regs.sv ----
`timescale 1ns/100ps
// Regulator protection/slew and oscillator configuration register bank
module regulator_clock_config_regs
  import regclk_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register access from the serial frame decoder
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [REG_SEL_W-1:0] reg_sel_i,
  input wire logic [REG_DATA_W-1:0] reg_wdata_i,
  output logic [REG_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_ready_o,
  // One-time-programmable defaults, static after power-up
  input wire logic [2:0] otp_thermal_action_i,
  input wire logic [1:0] otp_highside_slew_i,
  // Thermal shutdown events from the analog side
  input wire logic [2:0] thermal_shutdown_i,
  output logic [2:0] regulator_shutdown_o,
  output logic deep_failsafe_request_o,
  // Gate drive strength to the pre-regulator driver
  output slew_t prereg_lowside_slew_o,
  output slew_t prereg_highside_slew_o,
  // Main oscillator spread spectrum
  output logic spread_modulation_on_o,
  output spread_range_t spread_range_o,
  output logic [3:0] clock_tune_o,
  // Frequency output path
  input wire logic first_clock_option_i,
  input wire logic second_clock_option_i,
  output logic [3:0] freq_out_source_select_o,
  output logic freq_output_pin_o,
  // External frequency input path
  input wire logic freq_input_pin_i,
  output logic pll_ref_input_o,
  output logic external_input_select_request_o,
  // Live PLL status from the analog side
  input wire logic external_input_active_i,
  input wire logic pll_locked_i,
  // Whole configuration for other logic
  output prot_cfg_t prot_cfg_o,
  output osc_cfg_t osc_cfg_o
);

  // Register select decode, used by write, read and request paths
  // A single decode keeps the three paths from drifting apart
  function automatic logic hit(input logic [REG_SEL_W-1:0] sel,
                               input logic [REG_SEL_W-1:0] target);
    hit = (sel == target);
  endfunction

  bank_state_t state_reg; // Start-up sequencing
  prot_cfg_t prot_reg; // Protection and slew configuration
  osc_cfg_t osc_reg; // Oscillator configuration
  logic ext_req_reg; // One-cycle external-input request
  logic [REG_DATA_W-1:0] rdata_reg; // Read data stage
  logic rvalid_reg; // Read data valid
  logic run; // Bank accepts accesses

  // Synchronisers for asynchronous analog and pin inputs
  logic [2:0] tsd_meta_reg;
  logic [2:0] tsd_sync_reg;
  logic [2:0] tsd_prev_reg; // Previous synced level for edge detect
  logic [1:0] stat_meta_reg; // {pll lock, ext active}
  logic [1:0] stat_sync_reg;
  logic [1:0] clkopt_meta_reg; // {second, first}
  logic [1:0] clkopt_sync_reg;
  logic fin_meta_reg;
  logic fin_sync_reg;
  logic fin_prev_reg; // Previous synced input for edge detect
  logic [1:0] fin_cnt_reg; // Rising edges since last toggle
  logic external_input_divider_reg; // Divided-by-six square wave
  logic pll_ref_reg; // Selected PLL reference
  logic [2:0] shutdown_reg; // Shutdown pulses
  logic failsafe_reg; // Deep fail-safe pulse

  // Write data re-packed into the structs, reserved positions dropped
  prot_cfg_t prot_wr;
  osc_cfg_t osc_wr;

  assign run = (state_reg == ST_RUN);

  // Unpack host write data into field structs
  always_comb begin
    prot_wr.core_buck_thermal_action = reg_wdata_i[POS_CORE_TSD];
    prot_wr.second_buck_thermal_action = reg_wdata_i[POS_SECOND_TSD];
    prot_wr.linear_reg_thermal_action = reg_wdata_i[POS_LINEAR_TSD];
    prot_wr.prereg_lowside_slew = slew_t'(reg_wdata_i[POS_LOW_SLEW +: 2]);
    prot_wr.prereg_highside_slew = slew_t'(reg_wdata_i[POS_HIGH_SLEW +: 2]);
    osc_wr.spread_range_select = spread_range_t'(reg_wdata_i[POS_RANGE]);
    osc_wr.freq_out_source_select = reg_wdata_i[POS_SRC_SEL +: 4];
    osc_wr.freq_out_phase_shift = reg_wdata_i[POS_PHASE +: PHASE_W];
    osc_wr.freq_out_clock_choice = reg_wdata_i[POS_CLK_CHOICE];
    osc_wr.external_input_divider = reg_wdata_i[POS_DIVIDER];
    osc_wr.spread_spectrum_enable = reg_wdata_i[POS_SPREAD_EN];
    osc_wr.clock_tune = reg_wdata_i[POS_TUNE +: 4];
  end

  // Start-up: one cycle after reset release the OTP straps are captured
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_LOAD;
    end else begin
      // Two states only; both codes are legal, so no default arm
      unique case (state_reg)
        ST_LOAD: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
      endcase
    end
  end

  // Protection register; OTP fields cannot be taken under reset itself
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prot_reg.core_buck_thermal_action <= 1'b0;
      prot_reg.second_buck_thermal_action <= 1'b0;
      prot_reg.linear_reg_thermal_action <= 1'b0;
      prot_reg.prereg_lowside_slew <= slew_t'(LOW_SLEW_RESET);
      prot_reg.prereg_highside_slew <= SLEW_SLOW;
    end else if (!run) begin
      // Straps loaded at the first edge after release
      prot_reg.core_buck_thermal_action <= otp_thermal_action_i[0];
      prot_reg.second_buck_thermal_action <= otp_thermal_action_i[1];
      prot_reg.linear_reg_thermal_action <= otp_thermal_action_i[2];
      prot_reg.prereg_highside_slew <= slew_t'(otp_highside_slew_i);
    end else if (reg_wr_i && hit(reg_sel_i, SEL_PROT)) begin
      // Reserved positions never reach storage
      prot_reg <= prot_wr;
    end
  end

  // Oscillator register; the request bit is not stored
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_reg <= osc_cfg_t'(OSC_RESET);
    end else if (run && reg_wr_i && hit(reg_sel_i, SEL_OSC)) begin
      osc_reg <= osc_wr;
    end
  end

  // External input request: a one written makes a pulse, zero does nothing
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_req_reg <= 1'b0;
    end else begin
      // Not stored: the bit reads back as zero like a reserved one
      ext_req_reg <= run && reg_wr_i && hit(reg_sel_i, SEL_OSC)
                     && reg_wdata_i[POS_EXT_REQ];
    end
  end

  // Synchronise thermal events, status bits, clock options and input pin
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tsd_meta_reg <= '0;
      tsd_sync_reg <= '0;
      stat_meta_reg <= '0;
      stat_sync_reg <= '0;
      clkopt_meta_reg <= '0;
      clkopt_sync_reg <= '0;
      fin_meta_reg <= 1'b0;
      fin_sync_reg <= 1'b0;
    end else begin
      // First stage may go metastable; only the second stage is read
      tsd_meta_reg <= thermal_shutdown_i;
      tsd_sync_reg <= tsd_meta_reg;
      stat_meta_reg <= {pll_locked_i, external_input_active_i};
      stat_sync_reg <= stat_meta_reg;
      clkopt_meta_reg <= {second_clock_option_i, first_clock_option_i};
      clkopt_sync_reg <= clkopt_meta_reg;
      fin_meta_reg <= freq_input_pin_i;
      fin_sync_reg <= fin_meta_reg;
    end
  end

  // Thermal shutdown: each rising event shuts its regulator down, and
  // escalates to deep fail-safe where its action bit is set
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tsd_prev_reg <= '0;
      shutdown_reg <= '0;
      failsafe_reg <= 1'b0;
    end else begin
      // A level that stays high gives one pulse only; it must fall first
      tsd_prev_reg <= tsd_sync_reg;
      shutdown_reg <= tsd_sync_reg & ~tsd_prev_reg;
      failsafe_reg <= |(tsd_sync_reg & ~tsd_prev_reg & {prot_reg.linear_reg_thermal_action,
                        prot_reg.second_buck_thermal_action,
                        prot_reg.core_buck_thermal_action});
    end
  end

  // Divide-by-six: toggle every third rising edge of the synced input;
  // the input must stay below half the bank clock to be seen
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fin_prev_reg <= 1'b0;
      fin_cnt_reg <= '0;
      external_input_divider_reg <= 1'b0;
    end else begin
      fin_prev_reg <= fin_sync_reg;
      // Count rising edges only; the counter wraps at each toggle
      if (fin_sync_reg && !fin_prev_reg) begin
        if (fin_cnt_reg == FIN_HALF_LAST) begin
          fin_cnt_reg <= '0;
          external_input_divider_reg <= !external_input_divider_reg;
        end else begin
          fin_cnt_reg <= fin_cnt_reg + 2'h1;
        end
      end
    end
  end

  // Divider selection toward the PLL reference
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_ref_reg <= 1'b0;
    end else begin
      // Registered so the reference cannot glitch when the divider flips
      pll_ref_reg <= osc_reg.external_input_divider ? external_input_divider_reg : fin_sync_reg;
    end
  end

  // Frequency output clock choice feeds the phase delay
  logic freq_output_pin_clock_sel;
  assign freq_output_pin_clock_sel = osc_reg.freq_out_clock_choice ? clkopt_sync_reg[1]
                                                        : clkopt_sync_reg[0];

  // Phase shift in whole bank clock cycles
  // Limitation: one step is one bank cycle, coarser than a faster clock
  phase_delay_line #(
    .DEPTH(DELAY_DEPTH),
    .SEL_W(PHASE_W)
  ) u_phase (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .data_i(freq_output_pin_clock_sel),
    .shift_i(osc_reg.freq_out_phase_shift),
    .data_o(freq_output_pin_o)
  );

  // Read data: reserved bits zero, request bit reads zero, status is live
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= run && reg_rd_i;
      if (run && reg_rd_i) begin
        if (hit(reg_sel_i, SEL_PROT)) begin
          // Reserved positions stay zero
          rdata_reg <= '0;
          rdata_reg[POS_CORE_TSD] <= prot_reg.core_buck_thermal_action;
          rdata_reg[POS_SECOND_TSD] <= prot_reg.second_buck_thermal_action;
          rdata_reg[POS_LINEAR_TSD] <= prot_reg.linear_reg_thermal_action;
          rdata_reg[POS_LOW_SLEW +: 2] <= prot_reg.prereg_lowside_slew;
          rdata_reg[POS_HIGH_SLEW +: 2] <= prot_reg.prereg_highside_slew;
        end else if (hit(reg_sel_i, SEL_OSC)) begin
          // Request position stays zero, the bit is write-only
          rdata_reg <= '0;
          rdata_reg[POS_RANGE] <= osc_reg.spread_range_select;
          rdata_reg[POS_SRC_SEL +: 4] <= osc_reg.freq_out_source_select;
          rdata_reg[POS_PHASE +: PHASE_W] <= osc_reg.freq_out_phase_shift;
          rdata_reg[POS_CLK_CHOICE] <= osc_reg.freq_out_clock_choice;
          rdata_reg[POS_DIVIDER] <= osc_reg.external_input_divider;
          rdata_reg[POS_SPREAD_EN] <= osc_reg.spread_spectrum_enable;
          rdata_reg[POS_TUNE +: 4] <= osc_reg.clock_tune;
        end else if (hit(reg_sel_i, SEL_STATUS)) begin
          // Live synced levels, never latched
          rdata_reg <= '0;
          rdata_reg[POS_PLL_LOCK] <= stat_sync_reg[1];
          rdata_reg[POS_EXT_ACTIVE] <= stat_sync_reg[0];
        end else begin
          // Unmapped select reads zero
          rdata_reg <= '0;
        end
      end
    end
  end

  // Outputs
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  // Ready is low under reset and in the strap load cycle
  assign reg_ready_o = run;
  assign regulator_shutdown_o = shutdown_reg;
  assign deep_failsafe_request_o = failsafe_reg;
  assign prereg_lowside_slew_o = prot_reg.prereg_lowside_slew;
  assign prereg_highside_slew_o = prot_reg.prereg_highside_slew;
  // Range is only meaningful while modulating
  assign spread_modulation_on_o = osc_reg.spread_spectrum_enable;
  assign spread_range_o = osc_reg.spread_range_select;
  assign clock_tune_o = osc_reg.clock_tune;
  assign freq_out_source_select_o = osc_reg.freq_out_source_select;
  assign pll_ref_input_o = pll_ref_reg;
  // Pulse only; the clock side owns the actual switch-over
  assign external_input_select_request_o = ext_req_reg;
  // Full images for logic outside this bank
  assign prot_cfg_o = prot_reg;
  assign osc_cfg_o = osc_reg;

endmodule

// ---- verification/host_access_model.sv ----
`timescale 1ns/100ps
// Host side of the register port: one strobe cycle per access
module host_access_model
  import regclk_pkg::*;
(
  // Clock and the bank's ready
  input wire logic clock_i,
  input wire logic reg_ready_i,
  // Access toward the bank
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [REG_SEL_W-1:0] reg_sel_o,
  output logic [REG_DATA_W-1:0] reg_wdata_o
);
  // Idle: no strobe, data holds a junk pattern
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_sel_o = 2'h3;
    reg_wdata_o = 16'hA5A5;
  end

  // One access; signals held until an edge samples ready high
  task automatic access(input logic wr, input logic [REG_SEL_W-1:0] sel,
                        input logic [REG_DATA_W-1:0] d);
    logic [REG_DATA_W-1:0] m;
    m = (sel == SEL_PROT) ? PROT_RMASK : 16'hFFFF;
    @(posedge clock_i);
    #1;
    reg_sel_o = sel;
    reg_wdata_o = d & m;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    do begin
      @(posedge clock_i);
    end while (reg_ready_i !== 1'b1);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // Released data must not look like the last word
    reg_wdata_o = ~reg_wdata_o;
  endtask
endmodule

// ---- verification/regclk_checker_assertions.sv ----
`timescale 1ns/100ps
// Port-level watcher for the configuration bank
module regclk_checker_assertions
  import regclk_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [REG_SEL_W-1:0] reg_sel_i,
  input wire logic [REG_DATA_W-1:0] reg_wdata_i,
  input wire logic [REG_DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_ready_o,
  // Thermal path
  input wire logic [2:0] thermal_shutdown_i,
  input wire logic [2:0] regulator_shutdown_o,
  input wire logic deep_failsafe_request_o,
  // Configuration outputs
  input wire slew_t prereg_lowside_slew_o,
  input wire slew_t prereg_highside_slew_o,
  input wire logic spread_modulation_on_o,
  input wire spread_range_t spread_range_o,
  input wire logic external_input_select_request_o,
  input wire prot_cfg_t prot_cfg_o,
  input wire osc_cfg_t osc_cfg_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Action bits in shutdown-bit order, core buck first; the fail-safe pulse
  // is formed from the bits as they stood before its edge
  logic [2:0] act;
  assign act = {prot_cfg_o.linear_reg_thermal_action, prot_cfg_o.second_buck_thermal_action,
                prot_cfg_o.core_buck_thermal_action};

  // Accepted accesses; ready low means the strobe is dropped
  sequence osc_wr_s;
    reg_wr_i && reg_ready_o && reg_sel_i == SEL_OSC;
  endsequence
  sequence prot_wr_s;
    reg_wr_i && reg_ready_o && reg_sel_i == SEL_PROT;
  endsequence
  sequence osc_rd_s;
    reg_rd_i && reg_ready_o && reg_sel_i == SEL_OSC;
  endsequence

  req_pulse_a: assert property (osc_wr_s ##0 reg_wdata_i[POS_EXT_REQ] |=>
    external_input_select_request_o) else $error("request pulse missing");
  req_quiet_a: assert property (!(reg_wr_i && reg_ready_o && reg_sel_i == SEL_OSC &&
    reg_wdata_i[POS_EXT_REQ]) |=> !external_input_select_request_o)
    else $error("request pulse without write");
  req_readback_a: assert property (osc_rd_s |=> reg_rvalid_o &&
    !reg_rdata_o[POS_EXT_REQ]) else $error("request bit read back");
  spread_en_a: assert property (osc_wr_s |=> spread_modulation_on_o ==
    $past(reg_wdata_i[POS_SPREAD_EN])) else $error("modulation enable wrong");
  spread_range_a: assert property (osc_wr_s |=> spread_range_o ==
    $past(reg_wdata_i[POS_RANGE])) else $error("spread range wrong");
  slew_write_a: assert property (prot_wr_s |=> {prereg_lowside_slew_o,
    prereg_highside_slew_o} == $past({reg_wdata_i[POS_LOW_SLEW+:2],
    reg_wdata_i[POS_HIGH_SLEW+:2]})) else $error("gate drive field wrong");
  deep_failsafe_state_a: assert property (deep_failsafe_request_o ==
    |(regulator_shutdown_o & $past(act))) else $error("fail-safe request mismatch");
  tsd_pulse_a: assert property ($rose(thermal_shutdown_i[0]) |->
    ##[2:5] regulator_shutdown_o[0]) else $error("shutdown pulse missing");
  reset_value_a: assert property ($rose(rst_n_i) |-> prereg_lowside_slew_o
    == SLEW_ULTRA && osc_cfg_o == OSC_RESET) else $error("reset value wrong");
endmodule

bind regulator_clock_config_regs regclk_checker_assertions u_regclk_checker_assertions (
  .clock_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_sel_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o, .reg_ready_o, .thermal_shutdown_i, .regulator_shutdown_o,
  .deep_failsafe_request_o, .prereg_lowside_slew_o, .prereg_highside_slew_o,
  .spread_modulation_on_o, .spread_range_o, .external_input_select_request_o,
  .prot_cfg_o, .osc_cfg_o);

// ---- verification/tb_regulator_clock_config_regs.sv ----
`timescale 1ns/100ps
// Self-checking bench for the configuration bank
module tb_regulator_clock_config_regs;
  import regclk_pkg::*;
  // Design signals
  logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_ready_o;
  logic [REG_SEL_W-1:0] reg_sel_i;
  logic [REG_DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic [2:0] otp_thermal_action_i, thermal_shutdown_i, regulator_shutdown_o;
  logic [1:0] otp_highside_slew_i;
  logic deep_failsafe_request_o, spread_modulation_on_o, first_clock_option_i;
  logic second_clock_option_i, freq_output_pin_o, freq_input_pin_i, pll_ref_input_o;
  logic external_input_select_request_o, external_input_active_i, pll_locked_i;
  logic [3:0] clock_tune_o, freq_out_source_select_o;
  slew_t prereg_lowside_slew_o, prereg_highside_slew_o;
  spread_range_t spread_range_o;
  prot_cfg_t prot_cfg_o;
  osc_cfg_t osc_cfg_o;
  // Bench state
  int failures = 0;
  int checks_done = 0;
  int n, i, cnt, sd, fs;
  logic prev;
  logic [15:0] d, e, e_rst;
  logic [15:0] exp_q[$]; // Notes for read results, oldest first
  logic [31:0] seed = 32'h27EE959B;

  regulator_clock_config_regs u_regulator_clock_config_regs (.*);
  host_access_model u_host_access_model (.clock_i, .reg_ready_i(reg_ready_o),
    .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_sel_o(reg_sel_i), .reg_wdata_o(reg_wdata_i));

  // 100 ns clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // Xorshift stimulus source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // Accesses; a read leaves its expected word in the queue
  task automatic rd(input logic [1:0] sel, input logic [15:0] want);
    exp_q.push_back(want);
    u_host_access_model.access(1'b0, sel, 16'h0);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [15:0] v);
    u_host_access_model.access(1'b1, sel, v);
  endtask

  // Each returned word meets the oldest note
  always @(posedge clock_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("unexpected at %0t: read data with no note", $time);
      end else begin
        check(reg_rdata_o, exp_q.pop_front());
      end
    end
  end

  initial begin
    rst_n_i = 1'b0;
    thermal_shutdown_i = 3'h0;
    first_clock_option_i = 1'b0;
    second_clock_option_i = 1'b0;
    freq_input_pin_i = 1'b0;
    external_input_active_i = 1'b0;
    pll_locked_i = 1'b0;
    otp_thermal_action_i = 3'(rnd());
    otp_highside_slew_i = 2'(rnd());
    repeat (5) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    // Defaults: straps, ultra low-side drive, quiet oscillator
    e_rst = 16'h0;
    e_rst[POS_CORE_TSD] = otp_thermal_action_i[0];
    e_rst[POS_SECOND_TSD] = otp_thermal_action_i[1];
    e_rst[POS_LINEAR_TSD] = otp_thermal_action_i[2];
    e_rst[POS_LOW_SLEW+:2] = 2'h3;
    e_rst[POS_HIGH_SLEW+:2] = otp_highside_slew_i;
    rd(SEL_PROT, e_rst);
    rd(SEL_OSC, OSC_RESET);
    $display("reset defaults done");
    // Random words, every slew code, unmapped place in between
    for (n = 0; n < 8; n++) begin
      d = 16'(rnd());
      if (n < 4) begin
        d[POS_LOW_SLEW+:2] = 2'(n);
        d[POS_HIGH_SLEW+:2] = 2'(3 - n);
      end
      wr(SEL_PROT, d);
      check(16'(prereg_lowside_slew_o), 16'(d[POS_LOW_SLEW+:2]));
      check(16'(prereg_highside_slew_o), 16'(d[POS_HIGH_SLEW+:2]));
      rd(SEL_PROT, d & PROT_RMASK);
      d = 16'(rnd());
      wr(SEL_OSC, d);
      check(16'(spread_modulation_on_o), 16'(d[POS_SPREAD_EN]));
      check(16'(spread_range_o), 16'(d[POS_RANGE]));
      wr(2'h3, ~d);
      rd(SEL_OSC, d & OSC_RMASK);
      rd(2'h3, 16'h0);
    end
    $display("register access done");
    // Live status, all four combinations
    for (n = 0; n < 4; n++) begin
      pll_locked_i = n[0];
      external_input_active_i = n[1];
      repeat (3) @(posedge clock_i);
      e = 16'h0;
      e[POS_PLL_LOCK] = n[0];
      e[POS_EXT_ACTIVE] = n[1];
      rd(SEL_STATUS, e);
    end
    $display("status done");
    // Core and linear escalate, second buck only shuts down
    wr(SEL_PROT, 16'h1200);
    for (n = 0; n < 3; n++) begin
      sd = 0;
      fs = 0;
      thermal_shutdown_i[n] = 1'b1;
      repeat (8) begin
        @(posedge clock_i);
        sd += int'(regulator_shutdown_o[n] === 1'b1);
        fs += int'(deep_failsafe_request_o === 1'b1);
      end
      #1;
      thermal_shutdown_i[n] = 1'b0;
      check(16'(sd), 16'h1);
      check(16'(fs), 16'(n != 1));
    end
    $display("thermal done");
    // Every phase with each clock option; with the second chosen, the first must not pass
    for (n = 0; n < 16; n++) begin
      d = 16'h0;
      d[POS_PHASE+:3] = 3'(n);
      d[POS_CLK_CHOICE] = n[3];
      wr(SEL_OSC, d);
      first_clock_option_i = n[3];
      repeat (12) @(posedge clock_i);
      #1;
      check(16'(freq_output_pin_o), 16'h0);
      first_clock_option_i = !n[3];
      second_clock_option_i = n[3];
      cnt = 0;
      while (freq_output_pin_o !== 1'b1 && cnt < 20) begin
        @(posedge clock_i);
        #1;
        cnt++;
      end
      check(16'(cnt), 16'(3 + n % 8));
      first_clock_option_i = 1'b0;
      second_clock_option_i = 1'b0;
      repeat (12) @(posedge clock_i);
    end
    $display("frequency output done");
    // 24 input rises: six-fold gives 8 toggles, straight gives 48
    for (n = 0; n < 2; n++) begin
      d = 16'h0;
      d[POS_DIVIDER] = !n[0];
      wr(SEL_OSC, d);
      repeat (4) @(posedge clock_i);
      cnt = 0;
      prev = pll_ref_input_o;
      for (i = 0; i < 104; i++) begin
        @(posedge clock_i);
        #1;
        if (i < 96 && i % 2 == 0) freq_input_pin_i = !freq_input_pin_i;
        cnt += int'(pll_ref_input_o !== prev);
        prev = pll_ref_input_o;
      end
      check(16'(cnt), (n == 0) ? 16'h8 : 16'h30);
    end
    $display("divider done");
    // Second power-on reset restores the defaults over a full oscillator word
    wr(SEL_OSC, 16'hFFFF);
    rst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    check(16'(clock_tune_o), 16'h0);
    check(16'(freq_out_source_select_o), 16'h0);
    rd(SEL_PROT, e_rst);
    rd(SEL_OSC, OSC_RESET);
    repeat (4) @(posedge clock_i);
    $display("second reset done");
    finish_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #(100 * 20000);
    failures++;
    finish_test();
  end

  // Verdict
  task automatic finish_test();
    failures += exp_q.size();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
endmodule
